// *** src/iac_indirect_access.sv ***
// Configuration-space index/data pairs that reach the internal indirect register spaces
`timescale 1ns/10ps
`include "iac_cfg.svh"
module iac_indirect_access
    import iac_pkg::*;
#(
    parameter int NUM_PORTS   = 11,
    parameter int PORT_IDX_W  = 16
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        cfg_req_in,
    input  wire logic        cfg_wr_in,
    input  wire logic [4:0]  cfg_dev_in,
    input  wire logic [2:0]  cfg_func_in,
    input  wire logic [7:0]  cfg_reg_in,
    input  wire logic [31:0] cfg_wdata_in,
    output logic             cfg_ready_out,
    output logic             cfg_ack_out,
    output logic             cfg_hit_out,
    output logic      [31:0] cfg_rdata_out,
    output logic             ind_req_out,
    output logic             ind_wr_out,
    output iac_space_t       ind_space_out,
    output logic      [3:0]  ind_target_out,
    output logic      [15:0] ind_addr_out,
    output logic      [31:0] ind_wdata_out,
    input  wire logic [31:0] ind_rdata_in
);
    localparam int SLOT_W = 4;

    initial begin
        if (NUM_PORTS != 11 || PORT_IDX_W != 16)
            $error("iac_indirect_access: port count and index width are fixed by the map");
    end

    // ------------------------------------------------------------------------
    // Request capture and sequencing
    // ------------------------------------------------------------------------
    iac_state_t  state_q, state_d;
    logic        wr_q;
    logic [4:0]  dev_q;
    logic [2:0]  func_q;
    logic [7:0]  reg_q;
    logic [31:0] wdata_q;
    logic [31:0] vis_q, misc_idx_q, host_idx_q, core_idx_q;
    logic        hit_q;
    logic [31:0] rdata_q;

    wire take    = cfg_req_in && state_q == IAC_ST_IDLE;
    wire in_look = state_q == IAC_ST_LOOK;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            IAC_ST_IDLE: if (cfg_req_in) state_d = IAC_ST_LOOK;
            IAC_ST_LOOK: state_d = IAC_ST_RESP;
            IAC_ST_RESP: state_d = IAC_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in)
            state_q <= IAC_ST_IDLE;
        else
            state_q <= state_d;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_q    <= 1'b0;
            dev_q   <= '0;
            func_q  <= '0;
            reg_q   <= '0;
            wdata_q <= `IAC_RST_WORD;
        end else if (take) begin
            wr_q    <= cfg_wr_in;
            dev_q   <= cfg_dev_in;
            func_q  <= cfg_func_in;
            reg_q   <= {cfg_reg_in[7:2], 2'b00};
            wdata_q <= cfg_wdata_in;
        end
    end

    // ------------------------------------------------------------------------
    // Function and register decode
    // ------------------------------------------------------------------------
    wire is_br   = dev_q == `IAC_DEV_BRIDGE && func_q == `IAC_FUNC_MAIN;
    wire is_clk  = dev_q == `IAC_DEV_BRIDGE && func_q == `IAC_FUNC_CLK;
    wire clk_vis = vis_q[`IAC_VIS_BIT];
    wire port_a  = dev_q >= `IAC_PORT_DEV_A_LO && dev_q <= `IAC_PORT_DEV_A_HI;
    wire port_b  = dev_q >= `IAC_PORT_DEV_B_LO && dev_q <= `IAC_PORT_DEV_B_HI;
    wire is_port = func_q == `IAC_FUNC_MAIN && (port_a || port_b);
    wire hit     = is_br || is_port || (is_clk && clk_vis);

    wire hit_vis      = is_br && reg_q == `IAC_OFF_VIS;
    wire hit_misc_idx = is_br && reg_q == `IAC_OFF_MISC_IDX;
    wire hit_misc_dat = is_br && reg_q == `IAC_OFF_MISC_DAT;
    wire hit_host_idx = is_br && reg_q == `IAC_OFF_HOST_IDX;
    wire hit_host_dat = is_br && reg_q == `IAC_OFF_HOST_DAT;
    wire hit_core_idx = is_br && reg_q == `IAC_OFF_CORE_IDX;
    wire hit_core_dat = is_br && reg_q == `IAC_OFF_CORE_DAT;
    wire hit_port_idx = is_port && reg_q == `IAC_OFF_CORE_IDX;
    wire hit_port_dat = is_port && reg_q == `IAC_OFF_CORE_DAT;
    wire hit_clk      = is_clk && clk_vis;

    // core-select field and the five accepted core codes
    wire [2:0] core_sel = core_idx_q[`IAC_SEL_HI:`IAC_SEL_LO];
    wire sel_r2  = core_sel == `IAC_SEL_SB || core_sel == `IAC_SEL_GP1;
    wire sel_r3  = core_sel == `IAC_SEL_GP2 || core_sel == `IAC_SEL_GP3A
                   || core_sel == `IAC_SEL_GP3B;
    wire sel_ok  = sel_r2 || sel_r3;
    wire host_wen = host_idx_q[`IAC_HOST_WEN_BIT];
    wire misc_wen = misc_idx_q[`IAC_MISC_WEN_BIT];

    // ------------------------------------------------------------------------
    // Bridge index registers
    // ------------------------------------------------------------------------
    wire wr_look = in_look && wr_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            vis_q      <= `IAC_RST_WORD;
            misc_idx_q <= `IAC_RST_WORD;
            host_idx_q <= `IAC_RST_WORD;
            core_idx_q <= `IAC_RST_WORD;
        end else begin
            if (wr_look && hit_vis)      vis_q      <= wdata_q;
            if (wr_look && hit_misc_idx) misc_idx_q <= wdata_q;
            if (wr_look && hit_host_idx) host_idx_q <= wdata_q;
            if (wr_look && hit_core_idx) core_idx_q <= wdata_q;
        end
    end

    // ------------------------------------------------------------------------
    // Per-port index storage
    // ------------------------------------------------------------------------
    wire in_a = cfg_dev_in <= `IAC_PORT_DEV_A_HI;
    wire [SLOT_W-1:0] rd_slot = cfg_dev_in[3:0]
                                - (in_a ? `IAC_SLOT_BASE_A : `IAC_SLOT_BASE_B);
    wire [SLOT_W-1:0] slot_q  = dev_q[3:0]
                                - (port_a ? `IAC_SLOT_BASE_A : `IAC_SLOT_BASE_B);
    logic [PORT_IDX_W-1:0] port_idx;

    // one index per port, read at the accepting edge from cfg_dev_in and used in the look cycle
    iac_port_index_mem #(
        .DEPTH (NUM_PORTS),
        .WIDTH (PORT_IDX_W),
        .AW    (SLOT_W)
    ) u_port_mem (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .we_in     (wr_look && hit_port_idx),
        .waddr_in  (slot_q),
        .wdata_in  (wdata_q[PORT_IDX_W-1:0]),
        .raddr_in  (rd_slot),
        .rdata_out (port_idx)
    );

    // ------------------------------------------------------------------------
    // Indirect access issue
    // ------------------------------------------------------------------------
    // unknown core codes issue nothing
    wire go_core = hit_core_dat && sel_ok;
    wire go_host = hit_host_dat && (!wr_q || host_wen);
    wire go_misc = hit_misc_dat && (!wr_q || misc_wen);
    wire go_clk  = hit_clk && reg_q != `IAC_OFF_ID;

    // data accesses reach the indexed location
    assign ind_req_out   = in_look && (go_core || hit_port_dat || go_host || go_misc || go_clk);
    assign ind_wr_out    = wr_q;
    assign ind_wdata_out = wdata_q;
    assign ind_space_out = hit_port_dat ? IAC_SP_PORT :
                           hit_host_dat ? IAC_SP_HOST :
                           hit_misc_dat ? IAC_SP_MISC :
                           is_clk       ? IAC_SP_CLK  : IAC_SP_CORE;
    // one pair serves all five cores
    assign ind_target_out = hit_port_dat ? slot_q : {1'b0, core_sel};
    // host-link 8-bit index; miscellaneous 8-bit index
    assign ind_addr_out  = hit_port_dat ? port_idx :
                           hit_host_dat ? {8'h00, host_idx_q[7:0]} :
                           hit_misc_dat ? {8'h00, misc_idx_q[7:0]} :
                           is_clk       ? {8'h00, reg_q} : core_idx_q[15:0];

    // ------------------------------------------------------------------------
    // Answer
    // ------------------------------------------------------------------------
    // refused core reads return zero
    wire [31:0] rd_word = !hit          ? `IAC_RD_ABSENT :
                          ind_req_out   ? ind_rdata_in :
                          hit_vis       ? vis_q :
                          hit_misc_idx  ? misc_idx_q :
                          hit_host_idx  ? host_idx_q :
                          hit_core_idx  ? core_idx_q :
                          hit_port_idx  ? {16'h0000, port_idx} : `IAC_RD_ZERO;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hit_q   <= 1'b0;
            rdata_q <= `IAC_RD_ZERO;
        end else if (in_look) begin
            hit_q   <= hit;
            rdata_q <= wr_q ? `IAC_RD_ZERO : rd_word;
        end
    end

    assign cfg_ready_out = state_q == IAC_ST_IDLE;
    assign cfg_ack_out   = state_q == IAC_ST_RESP;
    assign cfg_hit_out   = hit_q;
    assign cfg_rdata_out = rdata_q;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    a_req_ack_time: assert property (take |-> ##2 cfg_ack_out && $past(in_look))
        else $error("config access not answered two cycles after acceptance");
    a_core_sb_route: assert property (
        in_look && hit_core_dat && core_sel == `IAC_SEL_SB |-> ind_req_out
        && ind_space_out == IAC_SP_CORE && ind_target_out == {1'b0, `IAC_SEL_SB})
        else $error("southbridge core code not routed to its core");
    a_core_gp_route: assert property (
        ind_req_out && ind_space_out == IAC_SP_CORE
        |-> ind_target_out inside {{1'b0, `IAC_SEL_SB}, {1'b0, `IAC_SEL_GP1},
        {1'b0, `IAC_SEL_GP2}, {1'b0, `IAC_SEL_GP3A}, {1'b0, `IAC_SEL_GP3B}})
        else $error("core access issued to an unlisted core");
    a_core_bad_zero: assert property (
        in_look && hit_core_dat && !sel_ok && !wr_q
        |-> !ind_req_out ##1 (cfg_ack_out && cfg_rdata_out == `IAC_RD_ZERO))
        else $error("unlisted core code not answered with zero");
    a_port_idx_addr: assert property (
        ind_req_out && ind_space_out == IAC_SP_PORT |-> ind_addr_out == port_idx && is_port)
        else $error("port access not using the port index");
    a_host_addr_gate: assert property (
        ind_req_out && ind_space_out == IAC_SP_HOST
        |-> ind_addr_out[15:8] == 8'h00 && (!ind_wr_out || host_idx_q[`IAC_HOST_WEN_BIT]))
        else $error("host-link write issued without the enable bit");
    a_misc_wr_gate: assert property (
        in_look && hit_misc_dat && wr_q && !misc_idx_q[`IAC_MISC_WEN_BIT] |-> !ind_req_out)
        else $error("miscellaneous write issued without the enable bit");
    a_clk_hidden_abs: assert property (
        in_look && is_clk && !clk_vis |=> !cfg_hit_out
        && cfg_rdata_out == ($past(wr_q) ? `IAC_RD_ZERO : `IAC_RD_ABSENT))
        else $error("hidden clock function answered");
    a_vis_reset_low: assert property ($past(rst_in) |-> !vis_q[`IAC_VIS_BIT])
        else $error("clock function visible after reset");
    a_clk_no_id: assert property (
        in_look && hit_clk && reg_q == `IAC_OFF_ID && !wr_q |=> cfg_rdata_out == `IAC_RD_ZERO)
        else $error("clock function returned an identification word");

    c_core_write: cover property (in_look && wr_q && go_core);
    c_port_read: cover property (in_look && !wr_q && hit_port_dat);
    c_clk_visible: cover property (in_look && hit_clk && go_clk);
    c_host_refused: cover property (in_look && hit_host_dat && wr_q && !host_wen);

endmodule : iac_indirect_access

// *** src/iac_cfg.svh ***
// Register offsets, field positions, codes and reset values of the indirect access block
//
// Summary of operation
// - The core-wide space is reached through an index register at core_space_index and a data register at core_space_data of bus 0 device 0, data accesses acting on the indexed location.
// - Core-select code 0x5 in index bits 18:16 routes data accesses to the southbridge link core only, and 0x4 to general port core one only.
// - Core-select codes 0x6, 0x7 and 0x3 route data accesses to general port core two, three-a and three-b only.
// - All five link cores are reached, one at a time, through the single core-wide index and data pair.
// - Each port bridge on devices 2 to 7 and 9 to 13 has its own 16-bit index at core_space_index and 32-bit data register at core_space_data.
// - The host-link space uses an 8-bit index in bits 7:0 of host_link_space_index and a 32-bit data register at host_link_space_data on device 0.
// - Host-link data writes take effect only while bit 8 of the host-link index register is set.
// - The miscellaneous space uses an index in bits 7:0 of misc_space_index and a 32-bit data register at misc_space_data on device 0.
// - Miscellaneous data writes take effect only while bit 7 of the miscellaneous index register is set.
// - The clock-control function at device 0 function 1 is absent after reset and visible only while bit 0 of offset 0x4c is 1.
// - The clock-control function implements no device or vendor identification register.
`ifndef IAC_CFG_SVH
`define IAC_CFG_SVH

// ----------------------------------------------------------------------------
// Device and function numbers
// ----------------------------------------------------------------------------
`define IAC_DEV_BRIDGE     5'h00
`define IAC_FUNC_MAIN      3'h0
`define IAC_FUNC_CLK       3'h1
`define IAC_PORT_DEV_A_LO  5'h02
`define IAC_PORT_DEV_A_HI  5'h07
`define IAC_PORT_DEV_B_LO  5'h09
`define IAC_PORT_DEV_B_HI  5'h0d
`define IAC_SLOT_BASE_A    4'h2
`define IAC_SLOT_BASE_B    4'h3

// ----------------------------------------------------------------------------
// Configuration offsets
// ----------------------------------------------------------------------------
`define IAC_OFF_VIS        8'h4c
`define IAC_OFF_MISC_IDX   8'h60
`define IAC_OFF_MISC_DAT   8'h64
`define IAC_OFF_HOST_IDX   8'h94
`define IAC_OFF_HOST_DAT   8'h98
`define IAC_OFF_CORE_IDX   8'he0
`define IAC_OFF_CORE_DAT   8'he4
`define IAC_OFF_ID         8'h00

// ----------------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------------
`define IAC_SEL_HI         18
`define IAC_SEL_LO         16
`define IAC_SEL_SB         3'h5
`define IAC_SEL_GP1        3'h4
`define IAC_SEL_GP2        3'h6
`define IAC_SEL_GP3A       3'h7
`define IAC_SEL_GP3B       3'h3
`define IAC_HOST_WEN_BIT   8
`define IAC_MISC_WEN_BIT   7
`define IAC_VIS_BIT        0

// ----------------------------------------------------------------------------
// Reset and answer values
// ----------------------------------------------------------------------------
`define IAC_RST_WORD       32'h0000_0000
`define IAC_RD_ABSENT      32'hffff_ffff
`define IAC_RD_ZERO        32'h0000_0000

`endif

// *** src/iac_pkg.sv ***
// Types shared by the indirect access block
package iac_pkg;

    typedef enum logic [2:0] {
        IAC_SP_CORE,
        IAC_SP_PORT,
        IAC_SP_HOST,
        IAC_SP_MISC,
        IAC_SP_CLK
    } iac_space_t;

    typedef enum logic [1:0] {
        IAC_ST_IDLE,
        IAC_ST_LOOK,
        IAC_ST_RESP
    } iac_state_t;

endpackage : iac_pkg

// *** src/iac_port_index_mem.sv ***
// Per-port index storage with registered read data
`timescale 1ns/10ps
module iac_port_index_mem #(
    parameter int DEPTH = 11,
    parameter int WIDTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             we_in,
    input  wire logic [AW-1:0]    waddr_in,
    input  wire logic [WIDTH-1:0] wdata_in,
    input  wire logic [AW-1:0]    raddr_in,
    output logic      [WIDTH-1:0] rdata_out
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    initial begin
        if (DEPTH > (1 << AW) || DEPTH < 1)
            $error("iac_port_index_mem: depth does not fit address width");
    end

    // ------------------------------------------------------------------------
    // Storage, one entry per port bridge
    // ------------------------------------------------------------------------
    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        always_ff @(posedge clk_in) begin
            if (rst_in)
                mem_q[i] <= '0;
            else if (we_in && waddr_in == AW'(i))
                mem_q[i] <= wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in)
            rdata_out <= '0;
        else if (int'(raddr_in) < DEPTH)
            rdata_out <= mem_q[raddr_in];
        else
            rdata_out <= '0;
    end

endmodule : iac_port_index_mem

// *** verif/iac_indirect_access_tb.sv ***
// Self-checking testbench of the indirect access block
`timescale 1ns/10ps
`include "iac_cfg.svh"
module iac_indirect_access_tb
    import iac_pkg::*;
;
    logic        clk_in;
    logic        rst_in;
    logic        cfg_req_in;
    logic        cfg_wr_in;
    logic [4:0]  cfg_dev_in;
    logic [2:0]  cfg_func_in;
    logic [7:0]  cfg_reg_in;
    logic [31:0] cfg_wdata_in;
    logic        cfg_ready_out;
    logic        cfg_ack_out;
    logic        cfg_hit_out;
    logic [31:0] cfg_rdata_out;
    logic        ind_req_out;
    logic        ind_wr_out;
    iac_space_t  ind_space_out;
    logic [3:0]  ind_target_out;
    logic [15:0] ind_addr_out;
    logic [31:0] ind_wdata_out;
    logic [31:0] ind_rdata_in;
    logic [31:0] seed_q;
    int          failures;
    int          comparisons;
    int          n_ind;
    logic        m_wr;
    iac_space_t  m_sp;
    logic [3:0]  m_tg;
    logic [15:0] m_ad;
    logic [31:0] m_wd;

    iac_indirect_access #(.NUM_PORTS(11), .PORT_IDX_W(16)) dut_u (
        .clk_in         (clk_in),
        .rst_in         (rst_in),
        .cfg_req_in     (cfg_req_in),
        .cfg_wr_in      (cfg_wr_in),
        .cfg_dev_in     (cfg_dev_in),
        .cfg_func_in    (cfg_func_in),
        .cfg_reg_in     (cfg_reg_in),
        .cfg_wdata_in   (cfg_wdata_in),
        .cfg_ready_out  (cfg_ready_out),
        .cfg_ack_out    (cfg_ack_out),
        .cfg_hit_out    (cfg_hit_out),
        .cfg_rdata_out  (cfg_rdata_out),
        .ind_req_out    (ind_req_out),
        .ind_wr_out     (ind_wr_out),
        .ind_space_out  (ind_space_out),
        .ind_target_out (ind_target_out),
        .ind_addr_out   (ind_addr_out),
        .ind_wdata_out  (ind_wdata_out),
        .ind_rdata_in   (ind_rdata_in)
    );

    always #2.5 clk_in = ~clk_in;

    // Records every indirect request seen at a sampling edge
    always @(posedge clk_in) begin
        if (ind_req_out === 1'b1) begin
            n_ind = n_ind + 1;
            m_wr  = ind_wr_out;
            m_sp  = ind_space_out;
            m_tg  = ind_target_out;
            m_ad  = ind_addr_out;
            m_wd  = ind_wdata_out;
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed_q = seed_q ^ (seed_q << 13);
        seed_q = seed_q ^ (seed_q >> 17);
        seed_q = seed_q ^ (seed_q << 5);
        return seed_q;
    endfunction : rnd

    function automatic logic [3:0] slot(input int d);
        return (d <= 7) ? 4'(d - 2) : 4'(d - 3);
    endfunction : slot

    task automatic wrap_up();
        if (failures == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One config access; checks answer and the indirect request it caused
    task automatic xfer(input logic wr, input logic [4:0] dev, input logic [2:0] fn,
                        input logic [7:0] rg, input logic [31:0] wd, input logic hit,
                        input logic [31:0] erd, input int en, input iac_space_t sp,
                        input logic [3:0] tg, input logic [15:0] ad);
        logic [31:0] rv;
        logic        got;
        int          k;
        rv = rnd();
        got = 1'b0;
        @(negedge clk_in);
        cfg_req_in   = 1'b1;
        cfg_wr_in    = wr;
        cfg_dev_in   = dev;
        cfg_func_in  = fn;
        cfg_reg_in   = rg;
        cfg_wdata_in = wd;
        ind_rdata_in = rv;
        n_ind        = 0;
        for (k = 0; k < 20 && !got; k++) begin
            @(posedge clk_in);
            got = (cfg_ready_out === 1'b1);
        end
        if (!got) begin
            chk(32'(got), 32'h1);
            wrap_up();
        end
        @(negedge clk_in);
        cfg_req_in   = 1'b0;
        cfg_reg_in   = 8'(rnd());
        cfg_wdata_in = rnd();
        got = 1'b0;
        for (k = 0; k < 20 && !got; k++) begin
            @(posedge clk_in);
            #1;
            got = (cfg_ack_out === 1'b1);
        end
        if (!got) begin
            chk(32'(got), 32'h1);
            wrap_up();
        end
        chk(32'(cfg_hit_out), 32'(hit));
        chk(cfg_rdata_out, (en == 1 && !wr) ? rv : erd);
        chk(32'(n_ind), 32'(en));
        if (en == 1) begin
            chk(32'(m_wr), 32'(wr));
            chk(32'(m_sp), 32'(sp));
            chk(32'(m_ad), 32'(ad));
            if (sp == IAC_SP_CORE || sp == IAC_SP_PORT) chk(32'(m_tg), 32'(tg));
            if (wr) chk(m_wd, wd);
        end
    endtask : xfer

    task automatic wr_reg(input logic [4:0] dev, input logic [7:0] rg, input logic [31:0] wd);
        xfer(1'b1, dev, `IAC_FUNC_MAIN, rg, wd, 1'b1, `IAC_RD_ZERO, 0, IAC_SP_CORE,
             4'h0, 16'h0);
    endtask : wr_reg

    task automatic rd_reg(input logic [4:0] dev, input logic [7:0] rg, input logic [31:0] ex);
        xfer(1'b0, dev, `IAC_FUNC_MAIN, rg, 32'h0, 1'b1, ex, 0, IAC_SP_CORE,
             4'h0, 16'h0);
    endtask : rd_reg

    // Index with a write-enable bit: write refused while clear, accepted once set
    task automatic gated(input logic [7:0] io, input logic [7:0] dof, input int b,
                         input iac_space_t sp);
        logic [31:0] v;
        v = rnd();
        v[b] = 1'b0;
        wr_reg(5'h00, io, v);
        rd_reg(5'h00, io, v);
        xfer(1'b1, 5'h00, 3'h0, dof, rnd(), 1'b1, 32'h0, 0, sp, 4'h0, 16'h0);
        xfer(1'b0, 5'h00, 3'h0, dof, 32'h0, 1'b1, 32'h0, 1, sp,
             4'h0, {8'h00, v[7:0]});
        v[b] = 1'b1;
        wr_reg(5'h00, io, v);
        xfer(1'b1, 5'h00, 3'h0, dof, rnd(), 1'b1, 32'h0, 1, sp,
             4'h0, {8'h00, v[7:0]});
    endtask : gated

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] v;
        logic        lst;
        logic        fwd;
        clk_in = 1'b0; rst_in = 1'b1; cfg_req_in = 1'b0; cfg_wr_in = 1'b0;
        cfg_dev_in = 5'h00; cfg_func_in = 3'h0; cfg_reg_in = 8'h00;
        cfg_wdata_in = 32'h0; ind_rdata_in = 32'h0; seed_q = 32'h0000_ea7a;
        failures = 0; comparisons = 0; n_ind = 0;
        repeat (20) @(posedge clk_in);
        @(negedge clk_in);
        rst_in = 1'b0;
        rd_reg(5'h00, `IAC_OFF_CORE_IDX, `IAC_RST_WORD);
        rd_reg(5'h00, `IAC_OFF_HOST_IDX, `IAC_RST_WORD);
        rd_reg(5'h00, `IAC_OFF_MISC_IDX, `IAC_RST_WORD);
        rd_reg(5'h00, `IAC_OFF_VIS, `IAC_RST_WORD);
        xfer(1'b0, 5'h00, 3'h1, 8'h10, 32'h0, 1'b0, `IAC_RD_ABSENT, 0, IAC_SP_CLK,
             4'h0, 16'h0);
        for (int s = 0; s < 8; s++) begin
            v = rnd();
            v[18:16] = s[2:0];
            lst = (s >= 3);
            wr_reg(5'h00, `IAC_OFF_CORE_IDX, v);
            rd_reg(5'h00, `IAC_OFF_CORE_IDX, v);
            xfer(1'b1, 5'h00, 3'h0, `IAC_OFF_CORE_DAT, rnd(), 1'b1, 32'h0, int'(lst),
                 IAC_SP_CORE, {1'b0, s[2:0]}, v[15:0]);
            xfer(1'b0, 5'h00, 3'h0, `IAC_OFF_CORE_DAT, 32'h0, 1'b1, 32'h0, int'(lst),
                 IAC_SP_CORE, {1'b0, s[2:0]}, v[15:0]);
        end
        for (int d = 2; d < 14; d++) begin
            v = rnd();
            if (d == 8) begin
                xfer(1'b0, 5'd8, 3'h0, 8'he0, 32'h0, 1'b0, `IAC_RD_ABSENT, 0, IAC_SP_PORT,
                     4'h0, 16'h0);
            end else begin
                wr_reg(5'(d), `IAC_OFF_CORE_IDX, v);
                rd_reg(5'(d), `IAC_OFF_CORE_IDX, {16'h0000, v[15:0]});
                xfer(1'b1, 5'(d), 3'h0, `IAC_OFF_CORE_DAT, rnd(), 1'b1, 32'h0, 1, IAC_SP_PORT,
                     slot(d), v[15:0]);
                xfer(1'b0, 5'(d), 3'h0, `IAC_OFF_CORE_DAT, 32'h0, 1'b1, 32'h0, 1, IAC_SP_PORT,
                     slot(d), v[15:0]);
            end
        end
        gated(`IAC_OFF_HOST_IDX, `IAC_OFF_HOST_DAT, `IAC_HOST_WEN_BIT, IAC_SP_HOST);
        gated(`IAC_OFF_MISC_IDX, `IAC_OFF_MISC_DAT, `IAC_MISC_WEN_BIT, IAC_SP_MISC);
        for (int p = 0; p < 2; p++) begin
            fwd = (p == 0);
            wr_reg(5'h00, `IAC_OFF_VIS, {31'h0, fwd});
            rd_reg(5'h00, `IAC_OFF_VIS, {31'h0, fwd});
            xfer(1'b0, 5'h00, 3'h1, `IAC_OFF_ID, 32'h0, fwd, fwd ? 32'h0 : `IAC_RD_ABSENT, 0,
                 IAC_SP_CLK, 4'h0, 16'h0);
            xfer(1'b0, 5'h00, 3'h1, 8'h10, 32'h0, fwd, `IAC_RD_ABSENT, int'(fwd),
                 IAC_SP_CLK, 4'h0, 16'h0010);
            if (fwd) begin
                xfer(1'b1, 5'h00, 3'h1, `IAC_OFF_ID, rnd(), 1'b1, 32'h0, 0, IAC_SP_CLK,
                     4'h0, 16'h0);
                xfer(1'b1, 5'h00, 3'h1, 8'h40, rnd(), 1'b1, 32'h0, 1, IAC_SP_CLK,
                     4'h0, 16'h0040);
            end else begin
                xfer(1'b1, 5'h00, 3'h1, 8'h40, rnd(), 1'b0, `IAC_RD_ZERO, 0, IAC_SP_CLK,
                     4'h0, 16'h0);
            end
        end
        wrap_up();
    end
endmodule : iac_indirect_access_tb
